/* File: dds_params.svh */
// constants for the diagnostic done status block: offsets, fields, reset values, mode codes
`ifndef DDS_PARAMS_SVH
`define DDS_PARAMS_SVH

// ****************************************************************
// register bus
// ****************************************************************
`define DDS_ADDR_W          16
`define DDS_DATA_W          8
`define DDS_DIAG_ADDR       16'h0526
`define DDS_IRQ_STAT_ADDR   16'h0600
`define DDS_IRQ_MASK_ADDR   16'h0601
`define DDS_RUN_ADDR        16'h0602

// ****************************************************************
// fields of diag_done_status and of the interrupt registers
// ****************************************************************
`define DDS_NUM_FLAGS       5
`define DDS_BIT_TEMP_SCAN   4
`define DDS_BIT_VOLT_SCAN   3
`define DDS_BIT_TEMP_BIST   2
`define DDS_BIT_VOLT_BIST   1
`define DDS_BIT_SUPPLY_BIST 0
`define DDS_DIAG_RESET      8'h00
`define DDS_IRQ_MASK_RESET  5'h00
`define DDS_RSVD_PAD        3'h0

// ****************************************************************
// monitor select codes
// ****************************************************************
`define DDS_MODE_SCAN       2'h1
`define DDS_MODE_BIST       2'h2

`endif

/* File: dds_pkg.sv */
// types shared by the diagnostic done status block
package dds_pkg;

   // start requests as written by software into the monitor control registers
   typedef struct packed {
      logic       temp_monitor_go;
      logic [1:0] temp_monitor_select;
      logic       volt_monitor_go;
      logic [1:0] volt_monitor_select;
      logic       supply_check_go;
   } dds_start_s;

   // one-cycle completion strobes from the comparator and supply checkers
   typedef struct packed {
      logic temp_scan_cycle;
      logic volt_scan_cycle;
      logic temp_selftest_cycle;
      logic volt_selftest_cycle;
      logic supply_selftest_cycle;
   } dds_cycle_s;

   // register bus request
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } dds_bus_s;

endpackage : dds_pkg

/* File: dds_flag.sv */
// one done flag: cleared when its run starts, set when a cycle of that run completes
`timescale 1ns/100ps
`default_nettype none

module dds_flag #(
   parameter bit ONE_SHOT = 1'b1
) (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic start_i,
   input  wire logic cycle_done_i,
   output logic      done_o,
   output logic      running_o,
   output logic      set_o
);

   logic done_r;
   logic running_r;
   logic set_r;
   logic hit;

   // a completion only counts for a run that was started, so the flag stays 0 before any start
   assign hit = cycle_done_i & running_r;

   // ****************************************************************
   // run tracking
   // ****************************************************************
   // a round robin keeps running after its first cycle; a self-test ends with its cycle
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         running_r <= 1'b0;
      end else if (start_i) begin
         running_r <= 1'b1;
      end else if (hit && ONE_SHOT) begin
         running_r <= 1'b0;
      end
   end

   // ****************************************************************
   // done flag
   // ****************************************************************
   // set wins over a start in the same cycle so a finished cycle is never lost
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         done_r <= 1'b0;
      end else if (hit) begin
         done_r <= 1'b1;
      end else if (start_i) begin
         done_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         set_r <= 1'b0;
      end else begin
         set_r <= hit & ~done_r;
      end
   end

   assign done_o    = done_r;
   assign running_o = running_r;
   assign set_o     = set_r;

endmodule // dds_flag

`default_nettype wire

/* File: dds_status.sv */
// diagnostic done status: five completion flags, their read-only register and an interrupt
`timescale 1ns/100ps
`default_nettype none
`include "dds_params.svh"

// Operation
// - temperature go with round-robin select clears bit 4; first completed cycle sets it
// - voltage go with round-robin select clears bit 3; first completed cycle sets it
// - go with self-test select clears bit 2 or 1; completed self-test sets it
// - supply check go clears bit 0; completed supply self-test sets it
// - self-test flags read 0 before start and while running, 1 after completion

module dds_status
   import dds_pkg::*;
#(
   parameter int ADDR_W    = `DDS_ADDR_W,
   parameter int DATA_W    = `DDS_DATA_W,
   parameter int NUM_FLAGS = `DDS_NUM_FLAGS
) (
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              we_i,
   input  wire logic              re_i,
   input  wire dds_start_s        start_i,
   input  wire dds_cycle_s        cycle_i,
   output logic [DATA_W-1:0]      rdata_o,
   output logic [NUM_FLAGS-1:0]   done_o,
   output logic                   irq_o
);

   // ****************************************************************
   // parameter check
   // ****************************************************************
   // the map is fixed: five flags under three reserved bits, sixteen bit offsets at least
   if (ADDR_W < `DDS_ADDR_W || DATA_W != `DDS_DATA_W || NUM_FLAGS != `DDS_NUM_FLAGS) begin : g_bad_params
      $error("dds_status: parameter values not served by this register map");
   end

   // ****************************************************************
   // start decode
   // ****************************************************************
   logic                      temp_scan_start;
   logic                      volt_scan_start;
   logic                      temp_bist_start;
   logic                      volt_bist_start;
   logic                      supply_bist_start;
   logic [`DDS_NUM_FLAGS-1:0] done;
   logic [`DDS_NUM_FLAGS-1:0] running;
   logic [`DDS_NUM_FLAGS-1:0] set_ev;

   // selects only matter in the cycle of their go pulse
   // other select codes start no run here and leave these flags alone
   assign temp_scan_start   = start_i.temp_monitor_go
                            & (start_i.temp_monitor_select == `DDS_MODE_SCAN);
   assign volt_scan_start   = start_i.volt_monitor_go
                            & (start_i.volt_monitor_select == `DDS_MODE_SCAN);
   assign temp_bist_start   = start_i.temp_monitor_go
                            & (start_i.temp_monitor_select == `DDS_MODE_BIST);
   assign volt_bist_start   = start_i.volt_monitor_go
                            & (start_i.volt_monitor_select == `DDS_MODE_BIST);
   assign supply_bist_start = start_i.supply_check_go;

   // ****************************************************************
   // done flags
   // ****************************************************************
   // round robin flags stay armed so later cycles keep them set
   dds_flag #(
      .ONE_SHOT     (1'b0)
   ) u_temp_scan (
      .clk_i        (clk_i),
      .reset_i      (reset_i),
      .start_i      (temp_scan_start),
      .cycle_done_i (cycle_i.temp_scan_cycle),
      .done_o       (done[`DDS_BIT_TEMP_SCAN]),
      .running_o    (running[`DDS_BIT_TEMP_SCAN]),
      .set_o        (set_ev[`DDS_BIT_TEMP_SCAN])
   );

   // the voltage round robin follows the same arming as the temperature one
   dds_flag #(
      .ONE_SHOT     (1'b0)
   ) u_volt_scan (
      .clk_i        (clk_i),
      .reset_i      (reset_i),
      .start_i      (volt_scan_start),
      .cycle_done_i (cycle_i.volt_scan_cycle),
      .done_o       (done[`DDS_BIT_VOLT_SCAN]),
      .running_o    (running[`DDS_BIT_VOLT_SCAN]),
      .set_o        (set_ev[`DDS_BIT_VOLT_SCAN])
   );

   // self-test flags disarm at completion, so they read 0 until the run ends
   dds_flag #(
      .ONE_SHOT     (1'b1)
   ) u_temp_bist (
      .clk_i        (clk_i),
      .reset_i      (reset_i),
      .start_i      (temp_bist_start),
      .cycle_done_i (cycle_i.temp_selftest_cycle),
      .done_o       (done[`DDS_BIT_TEMP_BIST]),
      .running_o    (running[`DDS_BIT_TEMP_BIST]),
      .set_o        (set_ev[`DDS_BIT_TEMP_BIST])
   );

   // voltage protector self-test
   dds_flag #(
      .ONE_SHOT     (1'b1)
   ) u_volt_bist (
      .clk_i        (clk_i),
      .reset_i      (reset_i),
      .start_i      (volt_bist_start),
      .cycle_done_i (cycle_i.volt_selftest_cycle),
      .done_o       (done[`DDS_BIT_VOLT_BIST]),
      .running_o    (running[`DDS_BIT_VOLT_BIST]),
      .set_o        (set_ev[`DDS_BIT_VOLT_BIST])
   );

   // supply self-test has no select code, its go alone starts it
   dds_flag #(
      .ONE_SHOT     (1'b1)
   ) u_supply_bist (
      .clk_i        (clk_i),
      .reset_i      (reset_i),
      .start_i      (supply_bist_start),
      .cycle_done_i (cycle_i.supply_selftest_cycle),
      .done_o       (done[`DDS_BIT_SUPPLY_BIST]),
      .running_o    (running[`DDS_BIT_SUPPLY_BIST]),
      .set_o        (set_ev[`DDS_BIT_SUPPLY_BIST])
   );

   // ****************************************************************
   // interrupt status and mask
   // ****************************************************************
   logic [`DDS_NUM_FLAGS-1:0] irq_stat_r;
   logic [`DDS_NUM_FLAGS-1:0] irq_stat_nxt;
   logic [`DDS_NUM_FLAGS-1:0] irq_mask_r;
   logic [`DDS_NUM_FLAGS-1:0] w1c;
   logic                      stat_wr;
   logic                      mask_wr;
   logic                      irq_r;
   logic                      irq_nxt;

   // full offset compare: a wider bus must not alias into these registers
   assign stat_wr = we_i && (addr_i == `DDS_IRQ_STAT_ADDR);
   assign mask_wr = we_i && (addr_i == `DDS_IRQ_MASK_ADDR);

   assign w1c = stat_wr ? wdata_i[`DDS_NUM_FLAGS-1:0] : {`DDS_NUM_FLAGS{1'b0}};

   // a completion landing with its own clear still sets the bit
   assign irq_stat_nxt = (irq_stat_r & ~w1c) | set_ev;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_stat_r <= {`DDS_NUM_FLAGS{1'b0}};
      end else begin
         irq_stat_r <= irq_stat_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_mask_r <= `DDS_IRQ_MASK_RESET;
      end else if (mask_wr) begin
         irq_mask_r <= wdata_i[`DDS_NUM_FLAGS-1:0];
      end
   end

   // the mask gates only the pin; status bits record events whether masked or not
   assign irq_nxt = |(irq_stat_r & irq_mask_r);

   // registered so the pin is glitch free; costs one cycle of latency
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // ****************************************************************
   // register read
   // ****************************************************************
   logic [`DDS_DATA_W-1:0] rdata_r;
   logic [`DDS_DATA_W-1:0] rdata_nxt;

   // the bus never waits: each read is answered in the cycle after its strobe
   // writes at the done status offset fall through here untouched
   always_comb begin
      rdata_nxt = `DDS_DIAG_RESET;
      if (re_i) begin
         unique case (addr_i)
            `DDS_DIAG_ADDR:     rdata_nxt = {`DDS_RSVD_PAD, done};
            `DDS_IRQ_STAT_ADDR: rdata_nxt = {`DDS_RSVD_PAD, irq_stat_r};
            `DDS_IRQ_MASK_ADDR: rdata_nxt = {`DDS_RSVD_PAD, irq_mask_r};
            `DDS_RUN_ADDR:      rdata_nxt = {`DDS_RSVD_PAD, running};
            default:            rdata_nxt = `DDS_DIAG_RESET;
         endcase
      end
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata_r <= `DDS_DIAG_RESET;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // every output comes straight from a flip-flop
   assign rdata_o = rdata_r;
   assign done_o  = done;
   assign irq_o   = irq_r;

endmodule // dds_status

`default_nettype wire

/* File: dds_status_chk.sv */
// concurrent checks on the ports of the diagnostic done status block
`timescale 1ns/100ps
`default_nettype none
`include "dds_params.svh"

// ****************************************************************
// checker
// ****************************************************************
module dds_status_chk
   import dds_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   reset_i,
   input  wire logic [`DDS_ADDR_W-1:0] addr_i,
   input  wire logic [`DDS_DATA_W-1:0] wdata_i,
   input  wire logic                   we_i,
   input  wire logic                   re_i,
   input  wire dds_start_s             start_i,
   input  wire dds_cycle_s             cycle_i,
   input  wire logic [`DDS_DATA_W-1:0] rdata_o,
   input  wire logic [`DDS_NUM_FLAGS-1:0] done_o,
   input  wire logic                   irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   // completion in the same cycle wins, so it is left out of the clear checks
   property p_temp_scan_clr;
      start_i.temp_monitor_go && start_i.temp_monitor_select == `DDS_MODE_SCAN && !cycle_i.temp_scan_cycle
         |=> !done_o[`DDS_BIT_TEMP_SCAN];
   endproperty
   a_temp_scan_clr: assert property (p_temp_scan_clr) else $error("temp scan flag not cleared");

   property p_volt_scan_clr;
      start_i.volt_monitor_go && start_i.volt_monitor_select == `DDS_MODE_SCAN && !cycle_i.volt_scan_cycle
         |=> !done_o[`DDS_BIT_VOLT_SCAN];
   endproperty
   a_volt_scan_clr: assert property (p_volt_scan_clr) else $error("volt scan flag not cleared");

   property p_temp_bist_clr;
      start_i.temp_monitor_go && start_i.temp_monitor_select == `DDS_MODE_BIST && !cycle_i.temp_selftest_cycle
         |=> !done_o[`DDS_BIT_TEMP_BIST];
   endproperty
   a_temp_bist_clr: assert property (p_temp_bist_clr) else $error("temp selftest flag not cleared");

   property p_volt_bist_clr;
      start_i.volt_monitor_go && start_i.volt_monitor_select == `DDS_MODE_BIST && !cycle_i.volt_selftest_cycle
         |=> !done_o[`DDS_BIT_VOLT_BIST];
   endproperty
   a_volt_bist_clr: assert property (p_volt_bist_clr) else $error("volt selftest flag not cleared");

   property p_sup_clr;
      start_i.supply_check_go && !cycle_i.supply_selftest_cycle |=> !done_o[`DDS_BIT_SUPPLY_BIST];
   endproperty
   a_sup_clr: assert property (p_sup_clr) else $error("supply selftest flag not cleared");

   property p_bist_rise;
      $rose(done_o[`DDS_BIT_TEMP_BIST]) |-> $past(cycle_i.temp_selftest_cycle);
   endproperty
   a_bist_rise: assert property (p_bist_rise) else $error("selftest flag set without completion");

   property p_sup_rise;
      $rose(done_o[`DDS_BIT_SUPPLY_BIST]) |-> $past(cycle_i.supply_selftest_cycle);
   endproperty
   a_sup_rise: assert property (p_sup_rise) else $error("supply flag set without completion");

   property p_rd_val;
      re_i && addr_i == `DDS_DIAG_ADDR |=> rdata_o == {`DDS_RSVD_PAD, $past(done_o)};
   endproperty
   a_rd_val: assert property (p_rd_val) else $error("status read data wrong");

   property p_rd_idle;
      !re_i |=> rdata_o == `DDS_DIAG_RESET;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");

   property p_wr_ign;
      we_i && addr_i == `DDS_DIAG_ADDR && start_i == '0 && cycle_i == '0 |=> $stable(done_o);
   endproperty
   a_wr_ign: assert property (p_wr_ign) else $error("status write changed flags");
endmodule // dds_status_chk

bind dds_status dds_status_chk u_chk (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .we_i(we_i), .re_i(re_i), .start_i(start_i), .cycle_i(cycle_i), .rdata_o(rdata_o), .done_o(done_o),
   .irq_o(irq_o));
`default_nettype wire

/* File: dds_status_tb_top.sv */
// self-checking testbench for the diagnostic done status block
`timescale 1ns/100ps
`default_nettype none
`include "dds_params.svh"

// ****************************************************************
// bench
// ****************************************************************
module dds_status_tb_top
   import dds_pkg::*;
;
   logic clk_i, reset_i, we_i, re_i, irq_o;
   logic [15:0] addr_i;
   logic [7:0]  wdata_i, rdata_o;
   logic [4:0]  done_o;
   dds_start_s  start_i;
   dds_cycle_s  cycle_i;
   int failures = 0, cmp_count = 0, cyc_n = 0;

   dds_status dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
      .re_i(re_i), .start_i(start_i), .cycle_i(cycle_i), .rdata_o(rdata_o), .done_o(done_o), .irq_o(irq_o));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic final_report();
      if (failures == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // hang guard: the whole run needs well under 200 cycles
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 2000) begin
         failures++;
         final_report();
      end
   end

   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a; wdata_i <= d; we_i <= 1'b1;
      @(posedge clk_i);
      we_i <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe, so compare there
   task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
      @(posedge clk_i);
      addr_i <= a; re_i <= 1'b1;
      @(posedge clk_i);
      re_i <= 1'b0;
      #1 chk(n, rdata_o, e);
   endtask

   task automatic go(input logic [6:0] v, input logic [4:0] e);
      @(posedge clk_i);
      start_i <= v;
      @(posedge clk_i);
      start_i <= '0;
      #1 chk("done after start", {3'h0, done_o}, {3'h0, e});
   endtask

   task automatic cyc(input logic [4:0] v, input logic [4:0] e);
      @(posedge clk_i);
      cycle_i <= v;
      @(posedge clk_i);
      cycle_i <= '0;
      #1 chk("done after cycle", {3'h0, done_o}, {3'h0, e});
   endtask

   task automatic t_reset();
      rd(`DDS_DIAG_ADDR, 8'h00, "status reset");
      rd(`DDS_IRQ_MASK_ADDR, 8'h00, "mask reset");
      cyc(5'h1F, 5'h00);
   endtask

   task automatic t_scan();
      go(7'b1_00_1_11_0, 5'h00);
      cyc(5'h18, 5'h00);
      go(7'b1_01_1_01_0, 5'h00);
      cyc(5'h18, 5'h18);
      go(7'b1_01_0_00_0, 5'h08);
      cyc(5'h10, 5'h18);
   endtask

   task automatic t_bist();
      go(7'b1_10_1_10_1, 5'h18);
      cyc(5'h04, 5'h1C);
      rd(`DDS_DIAG_ADDR, 8'h1C, "bist running");
      cyc(5'h03, 5'h1F);
      rd(`DDS_DIAG_ADDR, 8'h1F, "all done");
      rd(`DDS_DIAG_ADDR, 8'h1F, "read again");
   endtask

   task automatic t_regs();
      wr(`DDS_DIAG_ADDR, 8'h00);
      rd(`DDS_DIAG_ADDR, 8'h1F, "write ignored");
      rd(16'h0000, 8'h00, "unmapped read");
      rd(`DDS_RUN_ADDR, 8'h18, "runs armed");
   endtask

   task automatic t_irq();
      chk("irq masked", {7'h0, irq_o}, 8'h00);
      rd(`DDS_IRQ_STAT_ADDR, 8'h1F, "irq status");
      wr(`DDS_IRQ_MASK_ADDR, 8'h04);
      @(posedge clk_i);
      #1 chk("irq raised", {7'h0, irq_o}, 8'h01);
      wr(`DDS_IRQ_STAT_ADDR, 8'h04);
      @(posedge clk_i);
      #1 chk("irq cleared", {7'h0, irq_o}, 8'h00);
      rd(`DDS_IRQ_STAT_ADDR, 8'h1B, "irq status w1c");
   endtask

   // restart the self-test and voltage round-robin runs whose flags are set, so those clears are seen acting on a 1
   task automatic t_restart();
      go(7'b1_10_1_10_1, 5'h18);
      go(7'b0_00_1_01_0, 5'h10);
      cyc(5'h0F, 5'h1F);
      rd(`DDS_IRQ_STAT_ADDR, 8'h1F, "irq status again");
      chk("irq again", {7'h0, irq_o}, 8'h01);
   endtask

   initial begin
      reset_i = 1'b1; we_i = 1'b0; re_i = 1'b0;
      addr_i = '0; wdata_i = '0; start_i = '0; cycle_i = '0;
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      t_reset();
      t_scan();
      t_bist();
      t_regs();
      t_irq();
      t_restart();
      final_report();
   end
endmodule // dds_status_tb_top
`default_nettype wire
